// ===== core/fts_pkg.sv
// package: constants and carrier types for the silo buffer controller
package fts_pkg;
  localparam int WORD_W = 6;
  localparam int DEPTH_PAR = 13;
  localparam int DEPTH_SER = 11;
  localparam int CLK_MHZ = 20;
  localparam int STROBE_MIN_US = 5;
  localparam int STROBE_PERIOD_US = 40;
  localparam int DATA_SETUP_US = 1;
  localparam int STROBE_HIGH_CYC = STROBE_MIN_US * CLK_MHZ;
  localparam int STROBE_LOW_CYC = (STROBE_PERIOD_US - STROBE_MIN_US) * CLK_MHZ;
  localparam int SETUP_CYC = DATA_SETUP_US * CLK_MHZ;
  localparam int CNT_W = 12;
  localparam int SER_BITS = 7;
  // register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_IRQ = 4'h8;
  localparam logic [3:0] OFS_MASK = 4'hC;
  // control register bits
  localparam int CTRL_WR = 0;
  localparam int CTRL_RD = 1;
  localparam int CTRL_CLR = 2;
  localparam int CTRL_PAR = 3;
  localparam int CTRL_DATA_LO = 8;
  // status bits
  localparam int ST_BUSY = 0;
  localparam int ST_FIRST = 1;
  localparam int ST_TENTH = 2;
  localparam int ST_LAST = 3;
  localparam int ST_ANY = 4;
  localparam int ST_LOCK = 5;
  localparam int ST_DATA_LO = 8;
  // irq bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_LOCK = 1;
  localparam int IRQ_TENTH = 2;
  localparam int IRQ_ZERO = 3;
  localparam int IRQ_W = 4;

  typedef enum logic [2:0] {
    FTS_IDLE = 3'b000,
    FTS_SETUP = 3'b001,
    FTS_HIGH = 3'b011,
    FTS_LOW = 3'b010,
    FTS_CLEAR = 3'b110
  } fts_state_e;

  typedef struct packed {
    logic first_full;
    logic tenth_full;
    logic last_full;
    logic any_word_held;
  } fts_flags_s;
endpackage : fts_pkg

// ===== core/fts_sync3.sv
// three-stage input synchroniser for pins from the buffer
`timescale 1ns/10ps
`default_nettype none
module fts_sync3 #(
  parameter int W = 4
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [W-1:0] pin_in,
  output var logic [W-1:0] level_out
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] lvl_reg;
  logic [W-1:0] lvl_next;

  // ==================================================
  // change accepted once stages two and three agree
  always_comb begin
    lvl_next = lvl_reg;
    for (int i = 0; i < W; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        lvl_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      lvl_reg <= '0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end

  assign level_out = lvl_reg;
endmodule : fts_sync3
`default_nettype wire

// ===== core/fts_ctrl.sv
// controller driving the silo buffer pins from avalon-mm registers
//
// Local design decisions: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - drive format select high to load parallel words
// - serial word is a zero marker then six data bits
// - never send an all-zero serial word
// - any-word-held differing from first flag means lock-up; clear it (code only flags it in status and irq, the clear is left to software)
// - widen by six bits in parallel, deepen by 13 per device
// - strobe pulses at least 5 us wide, rate at most 25 kHz
// - side-by-side serial needs a marker before every sub-word
module fts_ctrl #(
  parameter int HIGH_CYC = fts_pkg::STROBE_HIGH_CYC,
  parameter int LOW_CYC = fts_pkg::STROBE_LOW_CYC,
  parameter int SU_CYC = fts_pkg::SETUP_CYC
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output var logic [31:0] avs_readdata_out,
  output var logic avs_waitrequest_out,
  output var logic irq_out,
  output var logic write_strobe_out,
  output var logic read_strobe_out,
  output var logic format_parallel_out,
  output var logic clear_out,
  output var logic [5:0] par_data_out,
  output var logic ser_data_out,
  input wire logic [5:0] buf_data_in,
  input wire logic first_full_in,
  input wire logic tenth_full_in,
  input wire logic last_full_in,
  input wire logic any_word_held_in
);
  // ==================================================
  // pin synchronisers
  logic [9:0] pin_lvl;
  fts_pkg::fts_flags_s flags;

  fts_sync3 #(.W(10)) u_sync (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .pin_in({buf_data_in, first_full_in, tenth_full_in, last_full_in,
             any_word_held_in}),
    .level_out(pin_lvl)
  );
  assign flags = pin_lvl[3:0];

  // ==================================================
  // state
  fts_pkg::fts_state_e st_reg, st_next;
  logic [fts_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic [2:0] bit_reg, bit_next;
  logic is_rd_reg, is_rd_next;
  logic par_reg, par_next;
  logic [5:0] wd_reg, wd_next;
  logic [5:0] rdata_reg, rdata_next;
  logic [fts_pkg::IRQ_W-1:0] irq_reg, irq_next;
  logic [fts_pkg::IRQ_W-1:0] mask_reg, mask_next;
  logic [31:0] rd_reg, rd_next;
  logic wait_reg, wait_next;
  logic irqo_reg, irqo_next;
  logic ws_reg, ws_next, rs_reg, rs_next, clr_reg, clr_next;
  logic [5:0] pd_reg, pd_next;
  logic sd_reg, sd_next;
  logic lock, lock_d_reg, ten_d_reg;
  logic [fts_pkg::IRQ_W-1:0] ev;
  logic acc;

  // mismatch between any-word-held and first flag
  assign lock = flags.any_word_held != flags.first_full;
  assign acc = (avs_read_in || avs_write_in) && wait_reg;

  // ==================================================
  // strobe sequencer and bus
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    bit_next = bit_reg;
    is_rd_next = is_rd_reg;
    par_next = par_reg;
    wd_next = wd_reg;
    rdata_next = rdata_reg;
    ws_next = ws_reg;
    rs_next = rs_reg;
    clr_next = clr_reg;
    pd_next = pd_reg;
    sd_next = sd_reg;
    mask_next = mask_reg;
    rd_next = rd_reg;
    wait_next = 1'b1;
    ev = '0;
    ev[fts_pkg::IRQ_LOCK] = lock && !lock_d_reg;
    ev[fts_pkg::IRQ_TENTH] = flags.tenth_full && !ten_d_reg;
    case (st_reg)
      fts_pkg::FTS_IDLE: begin
        cnt_next = '0;
      end
      fts_pkg::FTS_SETUP: begin
        // data settles before the rising strobe edge
        if (cnt_reg >= fts_pkg::CNT_W'(SU_CYC - 1)) begin
          cnt_next = '0;
          st_next = fts_pkg::FTS_HIGH;
          if (is_rd_reg) begin
            rs_next = 1'b1;
          end else begin
            ws_next = 1'b1;
          end
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      fts_pkg::FTS_HIGH: begin
        if (cnt_reg >= fts_pkg::CNT_W'(HIGH_CYC - 1)) begin
          cnt_next = '0;
          st_next = fts_pkg::FTS_LOW;
          // data sampled while the strobe is still high
          if (is_rd_reg) begin
            rdata_next = pin_lvl[9:4];
          end
          ws_next = 1'b0;
          rs_next = 1'b0;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      fts_pkg::FTS_LOW: begin
        if (cnt_reg >= fts_pkg::CNT_W'(LOW_CYC - 1)) begin
          cnt_next = '0;
          if (!is_rd_reg && !par_reg && bit_reg < 3'(fts_pkg::SER_BITS - 1))
          begin
            // next serial data bit, msb first after the marker
            bit_next = bit_reg + 1'b1;
            sd_next = wd_reg[3'(fts_pkg::SER_BITS - 2) - bit_reg];
            st_next = fts_pkg::FTS_SETUP;
          end else begin
            st_next = fts_pkg::FTS_IDLE;
            ev[fts_pkg::IRQ_DONE] = 1'b1;
          end
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      fts_pkg::FTS_CLEAR: begin
        // clear held as long as a strobe pulse for margin
        if (cnt_reg >= fts_pkg::CNT_W'(HIGH_CYC - 1)) begin
          clr_next = 1'b0;
          cnt_next = '0;
          st_next = fts_pkg::FTS_IDLE;
          ev[fts_pkg::IRQ_DONE] = 1'b1;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      default: begin
        st_next = fts_pkg::FTS_IDLE;
      end
    endcase
    if (acc) begin
      wait_next = 1'b0;
      rd_next = '0;
      if (avs_write_in) begin
        case (avs_address_in)
          fts_pkg::OFS_CTRL: begin
            if (st_reg == fts_pkg::FTS_IDLE) begin
              par_next = avs_writedata_in[fts_pkg::CTRL_PAR];
              wd_next = avs_writedata_in[fts_pkg::CTRL_DATA_LO +: 6];
              bit_next = '0;
              if (avs_writedata_in[fts_pkg::CTRL_CLR]) begin
                clr_next = 1'b1;
                st_next = fts_pkg::FTS_CLEAR;
              end else if (avs_writedata_in[fts_pkg::CTRL_RD]) begin
                is_rd_next = 1'b1;
                st_next = fts_pkg::FTS_SETUP;
              end else if (avs_writedata_in[fts_pkg::CTRL_WR]) begin
                is_rd_next = 1'b0;
                if (!avs_writedata_in[fts_pkg::CTRL_PAR] &&
                    avs_writedata_in[fts_pkg::CTRL_DATA_LO +: 6] == 6'h00)
                begin
                  ev[fts_pkg::IRQ_ZERO] = 1'b1;
                end else begin
                  pd_next = avs_writedata_in[fts_pkg::CTRL_DATA_LO +: 6];
                  sd_next = 1'b0; // marker first
                  st_next = fts_pkg::FTS_SETUP;
                end
              end
            end
          end
          fts_pkg::OFS_MASK: begin
            mask_next = avs_writedata_in[fts_pkg::IRQ_W-1:0];
          end
          default: begin
          end
        endcase
      end else begin
        case (avs_address_in)
          fts_pkg::OFS_CTRL: begin
            rd_next[fts_pkg::CTRL_PAR] = par_reg;
            rd_next[fts_pkg::CTRL_DATA_LO +: 6] = wd_reg;
          end
          fts_pkg::OFS_STATUS: begin
            rd_next[fts_pkg::ST_BUSY] = st_reg != fts_pkg::FTS_IDLE;
            rd_next[fts_pkg::ST_FIRST] = flags.first_full;
            rd_next[fts_pkg::ST_TENTH] = flags.tenth_full;
            rd_next[fts_pkg::ST_LAST] = flags.last_full;
            rd_next[fts_pkg::ST_ANY] = flags.any_word_held;
            rd_next[fts_pkg::ST_LOCK] = lock;
            rd_next[fts_pkg::ST_DATA_LO +: 6] = rdata_reg;
          end
          fts_pkg::OFS_IRQ: begin
            rd_next[fts_pkg::IRQ_W-1:0] = irq_reg;
          end
          fts_pkg::OFS_MASK: begin
            rd_next[fts_pkg::IRQ_W-1:0] = mask_reg;
          end
          default: begin
          end
        endcase
      end
    end
    // read clears, but a same-cycle event still sets
    irq_next = irq_reg;
    if (acc && avs_read_in && avs_address_in == fts_pkg::OFS_IRQ) begin
      irq_next = '0;
    end
    irq_next = irq_next | ev;
    irqo_next = |(irq_next & mask_next);
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_reg <= fts_pkg::FTS_IDLE;
      cnt_reg <= '0;
      bit_reg <= '0;
      is_rd_reg <= 1'b0;
      par_reg <= 1'b1;
      wd_reg <= '0;
      rdata_reg <= '0;
      irq_reg <= '0;
      mask_reg <= '0;
      rd_reg <= '0;
      wait_reg <= 1'b1;
      irqo_reg <= 1'b0;
      ws_reg <= 1'b0;
      rs_reg <= 1'b0;
      clr_reg <= 1'b0;
      pd_reg <= '0;
      sd_reg <= 1'b0;
      lock_d_reg <= 1'b0;
      ten_d_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      is_rd_reg <= is_rd_next;
      par_reg <= par_next;
      wd_reg <= wd_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
      mask_reg <= mask_next;
      rd_reg <= rd_next;
      wait_reg <= wait_next;
      irqo_reg <= irqo_next;
      ws_reg <= ws_next;
      rs_reg <= rs_next;
      clr_reg <= clr_next;
      pd_reg <= pd_next;
      sd_reg <= sd_next;
      lock_d_reg <= lock;
      ten_d_reg <= flags.tenth_full;
    end
  end

  assign avs_readdata_out = rd_reg;
  assign avs_waitrequest_out = wait_reg;
  assign irq_out = irqo_reg;
  assign write_strobe_out = ws_reg;
  assign read_strobe_out = rs_reg;
  assign format_parallel_out = par_reg;
  assign clear_out = clr_reg;
  assign par_data_out = pd_reg; // widen by tying devices side by side
  assign ser_data_out = sd_reg;
endmodule : fts_ctrl
`default_nettype wire

// ===== verif/fts_ctrl_chk.sv
// checker on the silo buffer controller ports
`timescale 1ns/10ps
`default_nettype none
module fts_ctrl_chk #(
  parameter int HIGH_CYC = 4,
  parameter int LOW_CYC = 4
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  input wire logic write_strobe_out,
  input wire logic read_strobe_out,
  input wire logic format_parallel_out,
  input wire logic clear_out,
  input wire logic [5:0] par_data_out,
  input wire logic ser_data_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  int wh_reg, wh_next, rh_reg, rh_next;
  int gap_reg, gap_next, sc_reg, sc_next;
  logic ws_reg;
  // gap saturates so it never wraps on long idle
  always_comb begin
    wh_next = write_strobe_out ? wh_reg + 1 : 0;
    rh_next = read_strobe_out ? rh_reg + 1 : 0;
    gap_next = (gap_reg < LOW_CYC) ? gap_reg + 1 : gap_reg;
    if (write_strobe_out || read_strobe_out) gap_next = 0;
    sc_next = sc_reg;
    if (clear_out) begin
      sc_next = 0;
    end else if (write_strobe_out && !ws_reg && !format_parallel_out) begin
      sc_next = (sc_reg == 6) ? 0 : sc_reg + 1;
    end
  end
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wh_reg <= 0;
      rh_reg <= 0;
      gap_reg <= LOW_CYC;
      sc_reg <= 0;
      ws_reg <= 1'b0;
    end else begin
      wh_reg <= wh_next;
      rh_reg <= rh_next;
      gap_reg <= gap_next;
      sc_reg <= sc_next;
      ws_reg <= write_strobe_out;
    end
  end
  bus_answer_a: assert property ((avs_read_in || avs_write_in) &&
    avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus request not answered next cycle");
  wait_pulse_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  wr_width_a: assert property ($fell(write_strobe_out) |-> wh_reg == HIGH_CYC)
    else $error("write strobe width wrong");
  rd_width_a: assert property ($fell(read_strobe_out) |-> rh_reg == HIGH_CYC)
    else $error("read strobe width wrong");
  strobe_gap_a: assert property (($rose(write_strobe_out) ||
    $rose(read_strobe_out)) |-> gap_reg >= LOW_CYC)
    else $error("strobes repeat too fast");
  strobe_excl_a: assert property (write_strobe_out |->
    !read_strobe_out && !clear_out)
    else $error("write strobe overlaps read or clear");
  data_hold_a: assert property (write_strobe_out |-> $stable(par_data_out) &&
    $stable(format_parallel_out) && $stable(ser_data_out))
    else $error("write data moved under strobe");
  marker_zero_a: assert property ($rose(write_strobe_out) &&
    !format_parallel_out && sc_reg == 0 |-> !ser_data_out)
    else $error("serial marker bit not zero");
endmodule : fts_ctrl_chk
`default_nettype wire

// ===== verif/fts_silo_model.sv
// behavioural silo buffer on the far side of the pins
`timescale 1ns/10ps
`default_nettype none
module fts_silo_model (
  input wire logic write_strobe_in,
  input wire logic read_strobe_in,
  input wire logic format_parallel_in,
  input wire logic clear_in,
  input wire logic [5:0] par_data_in,
  input wire logic ser_data_in,
  input wire logic lock_in,
  output var logic [5:0] data_out,
  output var fts_pkg::fts_flags_s flags_out
);
  // fall-through taken as instant, storage static
  // lone device: no cascade neighbour to strobe
  logic [5:0] q[$];
  logic [5:0] sh = 6'h00;
  int nb = 0;
  int n = 0;
  int cap;
  initial data_out = 6'h3F;
  assign cap = format_parallel_in ? fts_pkg::DEPTH_PAR :
    fts_pkg::DEPTH_SER;
  always @(posedge write_strobe_in) begin
    if (format_parallel_in) begin
      if (n < cap) q.push_back(par_data_in);
    end else begin
      // marker shifts out after seven strobes
      sh = {sh[4:0], ser_data_in};
      nb = (nb == 6) ? 0 : nb + 1;
      if (nb == 0 && n < cap) q.push_back(sh);
    end
    n = q.size();
  end
  always @(posedge read_strobe_in) begin
    if (n > 0) data_out = q.pop_front();
    n = q.size();
  end
  always @(negedge read_strobe_in) data_out = 6'h3F;
  always @(posedge clear_in) begin
    q.delete();
    nb = 0;
    n = 0;
  end
  assign flags_out = {n >= cap, n >= 4, n > 0,
    (n >= cap) ^ lock_in};
endmodule : fts_silo_model
`default_nettype wire

// ===== verif/fts_ctrl_test.sv
// testbench for the silo buffer controller
`timescale 1ns/10ps
`default_nettype none
module fts_ctrl_test;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [3:0] avs_address_in = 4'h0;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out, irq_out, write_strobe_out, read_strobe_out;
  logic format_parallel_out, clear_out, ser_data_out;
  logic [5:0] par_data_out, buf_data;
  logic lock_in = 1'b0;
  fts_pkg::fts_flags_s flags;
  int miscompares = 0;
  int num_checks = 0;
  always #25 clk_in = ~clk_in;
  // strobe outlasts the four-flop pin path so read data has settled
  fts_ctrl #(.HIGH_CYC(6), .LOW_CYC(4), .SU_CYC(2)) dut_u (
    .clk_in, .arst_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .irq_out,
    .write_strobe_out, .read_strobe_out, .format_parallel_out, .clear_out,
    .par_data_out, .ser_data_out, .buf_data_in(buf_data),
    .first_full_in(flags.first_full), .tenth_full_in(flags.tenth_full),
    .last_full_in(flags.last_full), .any_word_held_in(flags.any_word_held)
  );
  fts_silo_model dev_u (
    .write_strobe_in(write_strobe_out), .read_strobe_in(read_strobe_out),
    .format_parallel_in(format_parallel_out), .clear_in(clear_out),
    .par_data_in(par_data_out), .ser_data_in(ser_data_out), .lock_in,
    .data_out(buf_data), .flags_out(flags)
  );
  // ==========================================
  // bus and compare tasks
  task automatic bus(input logic w, input logic [3:0] a,
    input logic [31:0] d, output logic [31:0] r);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= w;
    avs_read_in <= !w;
    do @(posedge clk_in);
    while (avs_waitrequest_out !== 1'b0);
    r = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge clk_in);
  endtask : bus
  task automatic rd(input logic [3:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, r);
  endtask : rd
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : cmp
  // polls busy; extra cycles let the flag synchroniser settle
  task automatic op(input logic [31:0] c);
    logic [31:0] r;
    wr(fts_pkg::OFS_CTRL, c);
    do rd(fts_pkg::OFS_STATUS, r);
    while (r[fts_pkg::ST_BUSY] !== 1'b0);
    repeat (8) @(posedge clk_in);
  endtask : op
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run
  // ==========================================
  // scenarios
  task automatic t_reset;
    logic [31:0] r;
    cmp(32'(format_parallel_out), 32'h1);
    rd(fts_pkg::OFS_STATUS, r);
    cmp(32'(r[5:0]), 32'h0);
    rd(4'h2, r);
    cmp(r, 32'h0);
  endtask : t_reset
  task automatic t_par;
    logic [31:0] r;
    op(32'h0000_000C);
    for (int i = 1; i <= 14; i++) begin
      op({18'h0, i[5:0], 8'h09});
    end
    rd(fts_pkg::OFS_STATUS, r);
    cmp(32'(r[5:1]), 32'h0F);
    rd(fts_pkg::OFS_IRQ, r);
    cmp(32'(r[3:0]), 32'h5);
    for (int i = 1; i <= 14; i++) begin
      op(32'h0000_000A);
      rd(fts_pkg::OFS_STATUS, r);
      cmp(32'(r[13:8]), (i < 14) ? 32'(i) : 32'h3F);
    end
    cmp(32'(r[3:2]), 32'h0);
  endtask : t_par
  task automatic t_ser;
    logic [31:0] r;
    op(32'h0000_0004);
    for (int i = 1; i <= 12; i++) op({18'h0, i[5:0], 8'h01});
    rd(fts_pkg::OFS_STATUS, r);
    cmp(32'(r[1]), 32'h1);
    for (int i = 1; i <= 2; i++) begin
      op(32'h0000_0002);
      rd(fts_pkg::OFS_STATUS, r);
      cmp(32'(r[13:8]), 32'(i));
    end
    rd(fts_pkg::OFS_IRQ, r);
    op(32'h0000_0001);
    rd(fts_pkg::OFS_IRQ, r);
    cmp(32'(r[3:0]), 32'h8);
    op(32'h0000_0004);
    rd(fts_pkg::OFS_STATUS, r);
    cmp(32'(r[5:1]), 32'h0);
  endtask : t_ser
  task automatic t_irq;
    logic [31:0] r;
    wr(fts_pkg::OFS_MASK, 32'h1);
    rd(fts_pkg::OFS_IRQ, r);
    cmp(32'(irq_out), 32'h0);
    op(32'h0000_0109);
    cmp(32'(irq_out), 32'h1);
    rd(fts_pkg::OFS_IRQ, r);
    cmp(32'(r[3:0]), 32'h1);
    repeat (3) @(posedge clk_in);
    cmp(32'(irq_out), 32'h0);
    wr(fts_pkg::OFS_MASK, 32'h2);
    lock_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    rd(fts_pkg::OFS_STATUS, r);
    cmp(32'(r[5]), 32'h1);
    cmp(32'(irq_out), 32'h1);
    rd(fts_pkg::OFS_IRQ, r);
    lock_in <= 1'b0;
    op(32'h0000_000C);
    cmp(32'(irq_out), 32'h0);
    rd(fts_pkg::OFS_STATUS, r);
    cmp(32'(r[5:1]), 32'h0);
  endtask : t_irq
  initial begin
    repeat (5) @(posedge clk_in);
    arst_n_in <= 1'b1;
    t_reset;
    t_par;
    t_ser;
    t_irq;
    complete_run;
  end
  initial begin
    repeat (40000) @(posedge clk_in);
    miscompares++;
    complete_run;
  end
endmodule : fts_ctrl_test
bind fts_ctrl fts_ctrl_chk #(.HIGH_CYC(HIGH_CYC), .LOW_CYC(LOW_CYC)) chk_u (
  .clk_in, .arst_n_in, .avs_read_in, .avs_write_in, .avs_waitrequest_out,
  .write_strobe_out, .read_strobe_out, .format_parallel_out, .clear_out,
  .par_data_out, .ser_data_out
);
`default_nettype wire
